// >>> verilog/cosd_defines.vh
// constants for the clock output sync and digital delay block
// assumes: apb slave on pclk, pclk is the distribution path clock
`ifndef COSD_DEFINES_VH
`define COSD_DEFINES_VH

`define COSD_ADDR_W 8
`define COSD_OFF_CTRL 8'h00
`define COSD_OFF_GRP0 8'h04
`define COSD_OFF_GRP5 8'h18
`define COSD_OFF_LOOP2N 8'h1C
`define COSD_OFF_STATUS 8'h20
`define COSD_GRP_SHIFT 2

`define COSD_CTRL_POL 0
`define COSD_CTRL_TYPE_LO 1
`define COSD_CTRL_TYPE_HI 3
`define COSD_CTRL_UNLOCK1 4
`define COSD_CTRL_UNLOCK2 5
`define COSD_CTRL_QUAL 6
`define COSD_CTRL_AUTO 7
`define COSD_CTRL_VCO 8
`define COSD_CTRL_FB_LO 9
`define COSD_CTRL_FB_HI 11
`define COSD_CTRL_MASK 32'h00000FFF
`define COSD_CTRL_RESET 32'h00000100
`define COSD_TYPE_INPUT_MAX 3'h2

`define COSD_NGROUPS 6
`define COSD_FB_MAX 3'h5
`define COSD_GRP_DDLY_LO 0
`define COSD_GRP_DDLY_HI 9
`define COSD_GRP_HS 10
`define COSD_GRP_EXCL 11
`define COSD_GRP_OSC 12
`define COSD_GRP_DIV_LO 13
`define COSD_GRP_DIV_HI 22
`define COSD_GRP_MASK 32'h007FFFFF
`define COSD_GRP_RESET 32'h00002005
`define COSD_LOOP2N_MASK 32'h0003FFFF

`define COSD_PIPE_DEPTH 4
`define COSD_EVENT_WIDTH 2'h2
`define COSD_QUAL_DONE 3'h6
`define COSD_QUAL_ON 3'h3

`endif

// >>> verilog/cosd_sync_delay.v
// clock output groups with sync hold and programmed digital delay
// assumes: pclk is the distribution path clock; lock flags come from
// logic on pclk; sync pin is asynchronous
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cosd_defines.vh"

module cosd_sync_delay (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`COSD_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire sync_pin,
    input wire lock_detect_flag_loop1,
    input wire lock_detect_flag_loop2,
    output wire [`COSD_NGROUPS-1:0] group_clk_a,
    output wire [`COSD_NGROUPS-1:0] group_clk_b,
    output wire sync_hold
);

    // registers
    reg [31:0] ctrl;
    reg [31:0] loop2n;
    reg [31:0] grp_cfg [0:`COSD_NGROUPS-1];

    // apb decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire is_ctrl = (paddr == `COSD_OFF_CTRL);
    wire is_grp = (paddr >= `COSD_OFF_GRP0) && (paddr <= `COSD_OFF_GRP5)
        && (paddr[1:0] == 2'h0);
    wire is_loop2n = (paddr == `COSD_OFF_LOOP2N);
    wire is_status = (paddr == `COSD_OFF_STATUS);
    wire hit = is_ctrl | is_grp | is_loop2n | is_status;
    wire wr = access & pwrite & hit;
    wire [`COSD_ADDR_W-1:0] grp_off = paddr - `COSD_OFF_GRP0;
    wire [2:0] grp_idx = grp_off[`COSD_GRP_SHIFT+2:`COSD_GRP_SHIFT];

    // zero wait states; read data captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access & ~hit;

    // control fields
    wire pol = ctrl[`COSD_CTRL_POL];
    wire [2:0] sync_type = ctrl[`COSD_CTRL_TYPE_HI:`COSD_CTRL_TYPE_LO];
    wire sync_on_loop1_unlock = ctrl[`COSD_CTRL_UNLOCK1];
    wire sync_on_loop2_unlock = ctrl[`COSD_CTRL_UNLOCK2];
    wire sync_qualify_enable = ctrl[`COSD_CTRL_QUAL];
    wire auto_sync = ctrl[`COSD_CTRL_AUTO];
    wire vco_in_use = ctrl[`COSD_CTRL_VCO];
    wire [2:0] fb_sel = ctrl[`COSD_CTRL_FB_HI:`COSD_CTRL_FB_LO];

    // sync pin: three stages, a change counts once stages two and three agree
    reg pin_s1;
    reg pin_s2;
    reg pin_s3;
    reg pin_level;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_s1 <= sync_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_level <= pin_s3;
            end
        end
    end

    // input types compare pin against polarity, output types use polarity
    wire pin_is_input = (sync_type <= `COSD_TYPE_INPUT_MAX);
    wire pin_req = pin_is_input ? (pin_level != pol) : pol;

    // register-driven events become a short pulse so they are latched
    wire pol_toggle = wr & is_ctrl & (pwdata[`COSD_CTRL_POL] != pol);
    wire loop2n_sync = wr & is_loop2n & vco_in_use;
    wire auto_ev = wr & is_grp & auto_sync;
    wire ev_start = pol_toggle | loop2n_sync | auto_ev;
    reg [1:0] ev_cnt;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_cnt <= 2'h0;
        end else if (ev_start) begin
            ev_cnt <= `COSD_EVENT_WIDTH;
        end else if (ev_cnt != 2'h0) begin
            ev_cnt <= ev_cnt - 2'h1;
        end
    end

    wire unlock_req = (sync_on_loop1_unlock & ~lock_detect_flag_loop1) |
        (sync_on_loop2_unlock & ~lock_detect_flag_loop2);
    wire sync_req = pin_req | (ev_cnt != 2'h0) | unlock_req;

    // qualification against the selected group's clock
    wire [`COSD_NGROUPS-1:0] grp_core;
    wire [2:0] fb_idx = (fb_sel > `COSD_FB_MAX) ? 3'h0 : fb_sel;
    wire qual_clk = grp_core[fb_idx];
    reg qual_prev;
    reg req_prev;
    reg armed;
    reg [2:0] qcnt;
    wire qual_fall = qual_prev & ~qual_clk;
    // one-shot covers counts 4..6: starts three cycles after qualifying
    wire one_shot = (qcnt > `COSD_QUAL_ON);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qual_prev <= 1'b0;
            req_prev <= 1'b0;
            armed <= 1'b0;
            qcnt <= 3'h0;
        end else begin
            qual_prev <= qual_clk;
            req_prev <= sync_req;
            if (!sync_qualify_enable) begin
                armed <= 1'b0;
                qcnt <= 3'h0;
            end else begin
                if (armed & qual_fall) begin
                    armed <= 1'b0;
                    qcnt <= 3'h1;
                end else if (sync_req & ~req_prev) begin
                    armed <= 1'b1;
                end
                if (qcnt == `COSD_QUAL_DONE) begin
                    qcnt <= 3'h0;
                end else if (qcnt != 3'h0) begin
                    qcnt <= qcnt + 3'h1;
                end
            end
        end
    end

    // latch on the rising edge, then fixed latency pipe; with the group
    // stage and output flop this gives six cycles in total
    reg hold_lat;
    reg [`COSD_PIPE_DEPTH-1:0] hold_pipe;
    wire hold_late = hold_pipe[`COSD_PIPE_DEPTH-1];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_lat <= 1'b0;
            hold_pipe <= {`COSD_PIPE_DEPTH{1'b0}};
        end else begin
            hold_lat <= sync_qualify_enable ? one_shot : sync_req;
            hold_pipe <= {hold_pipe[`COSD_PIPE_DEPTH-2:0], hold_lat};
        end
    end

    assign sync_hold = hold_late;

    // register writes
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `COSD_CTRL_RESET;
            loop2n <= 32'h00000000;
            for (i = 0; i < `COSD_NGROUPS; i = i + 1) begin
                grp_cfg[i] <= `COSD_GRP_RESET;
            end
        end else if (wr) begin
            if (is_ctrl) begin
                ctrl <= pwdata & `COSD_CTRL_MASK;
            end
            if (is_loop2n) begin
                loop2n <= pwdata & `COSD_LOOP2N_MASK;
            end
            if (is_grp) begin
                grp_cfg[grp_idx] <= pwdata & `COSD_GRP_MASK;
            end
        end
    end

    // per-group divider and delay; one core feeds both outputs
    wire [`COSD_NGROUPS-1:0] grp_full;
    wire [`COSD_NGROUPS-1:0] grp_half;
    wire [`COSD_NGROUPS-1:0] grp_hs;
    genvar g;
    generate
        for (g = 0; g < `COSD_NGROUPS; g = g + 1) begin : grp
            wire [31:0] cfg = grp_cfg[g];
            wire [9:0] ddly = cfg[`COSD_GRP_DDLY_HI:`COSD_GRP_DDLY_LO];
            wire [9:0] div = cfg[`COSD_GRP_DIV_HI:`COSD_GRP_DIV_LO];
            wire [9:0] div_top = (div == 10'h000) ? 10'h000 : div - 10'h001;
            // excluded or oscillator-sourced groups never see the hold
            wire member = ~cfg[`COSD_GRP_EXCL] & ~cfg[`COSD_GRP_OSC];
            reg core;
            reg full_copy;
            reg half_copy;
            reg waiting;
            reg [9:0] dcnt;
            reg [9:0] divc;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    core <= 1'b0;
                    waiting <= 1'b0;
                    dcnt <= 10'h000;
                    divc <= 10'h000;
                end else if (hold_late & member) begin
                    core <= 1'b0;
                    waiting <= 1'b1;
                    // count taken only here, so later writes wait
                    // full count: four pipe edges plus count plus flop is 6+d
                    dcnt <= ddly;
                    divc <= 10'h000;
                end else if (waiting) begin
                    // each member leaves hold once its own delay count reaches zero
                    if (dcnt == 10'h000) begin
                        waiting <= 1'b0;
                        core <= 1'b1;
                    end else begin
                        dcnt <= dcnt - 10'h001;
                    end
                end else if (divc >= div_top) begin
                    divc <= 10'h000;
                    core <= ~core;
                end else begin
                    divc <= divc + 10'h001;
                end
            end

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    full_copy <= 1'b0;
                end else begin
                    full_copy <= core;
                end
            end

            // falling-edge copy is half a cycle ahead of the full one
            always @(negedge pclk or negedge presetn) begin
                if (!presetn) begin
                    half_copy <= 1'b0;
                end else begin
                    half_copy <= core;
                end
            end

            assign grp_full[g] = full_copy;
            assign grp_half[g] = half_copy;
            assign grp_core[g] = core;
            assign grp_hs[g] = cfg[`COSD_GRP_HS];
        end
    endgenerate

    // half-step selects the copy live, no sync needed
    // unqualified resync leaves phase to running groups open
    assign group_clk_a = (grp_hs & grp_half) | (~grp_hs & grp_full);
    assign group_clk_b = group_clk_a;

    // read data
    wire [31:0] status = {23'h000000, group_clk_a, armed, pin_level,
        hold_late};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup & ~pwrite) begin
            if (is_ctrl) begin
                prdata <= ctrl;
            end else if (is_grp) begin
                prdata <= grp_cfg[grp_idx];
            end else if (is_loop2n) begin
                prdata <= loop2n;
            end else if (is_status) begin
                prdata <= status;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule // cosd_sync_delay
`default_nettype wire

// >>> verification/cosd_sync_delay_checker.sv
// checker: port-level relations of the sync and delay block
// assumes: bound to cosd_sync_delay, zero-wait apb; request checks skip qualified mode
`timescale 1ns/1ps
`default_nettype none
`include "cosd_defines.vh"
module cosd_sync_delay_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`COSD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic sync_pin,
    input wire logic lock_detect_flag_loop1,
    input wire logic [`COSD_NGROUPS-1:0] group_clk_a,
    input wire logic [`COSD_NGROUPS-1:0] group_clk_b,
    input wire logic sync_hold
);
    logic [31:0] ctrl;
    logic [5:0] free;
    wire wr = psel && penable && pwrite;
    wire in_req = ctrl[3:1] <= 3'h2 && sync_pin != ctrl[0] && !ctrl[6];
    // shadow of the control bits and of the bits that decide which groups must be held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `COSD_CTRL_RESET;
            free <= 6'h00;
        end else if (wr && paddr == 8'h00) begin
            ctrl <= pwdata & `COSD_CTRL_MASK;
        end else if (wr && paddr >= 8'h04 && paddr <= 8'h18) begin
            free[(paddr - 8'h04) >> 2] <= pwdata[11] | pwdata[12];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pair_same: assert property (group_clk_a == group_clk_b)
        else $error("group pair outputs differ");
    a_hold_low: assert property (sync_hold [*3] |->
        (group_clk_a & ~free) == 6'h00) else $error("member not held low");
    a_release_wait: assert property ($fell(sync_hold) |->
        ((group_clk_a & ~free) == 6'h00) [*3]) else $error("early rise");
    a_pin_hold: assert property (in_req [*8] |-> ##[1:8] sync_hold)
        else $error("pin request not held");
    a_pol_toggle: assert property (wr && paddr == 8'h00 &&
        pwdata[0] != ctrl[0] && !ctrl[6] && !pwdata[6] |-> ##[1:8] sync_hold)
        else $error("polarity toggle gave no hold");
    a_loop2_sync: assert property (wr && paddr == 8'h1C &&
        ctrl[8] && !ctrl[6] |-> ##[1:8] sync_hold) else $error("no hold");
    a_auto_sync: assert property (wr && paddr >= 8'h04 &&
        paddr <= 8'h18 && ctrl[7] && !ctrl[6] |-> ##[1:8] sync_hold)
        else $error("auto write gave no hold");
    a_unlock_sync: assert property ((ctrl[4] && !ctrl[6] &&
        !lock_detect_flag_loop1) [*3] |-> ##[1:8] sync_hold)
        else $error("unlock gave no hold");
    a_ctrl_read: assert property (psel && penable && !pwrite &&
        paddr == 8'h00 |-> prdata == ctrl) else $error("ctrl readback");
    a_unmapped_err: assert property (psel && penable &&
        paddr > 8'h20 |-> pslverr) else $error("no error on unmapped");
endmodule // cosd_sync_delay_checker
bind cosd_sync_delay cosd_sync_delay_checker u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .sync_pin(sync_pin), .lock_detect_flag_loop1(lock_detect_flag_loop1),
    .group_clk_a(group_clk_a), .group_clk_b(group_clk_b),
    .sync_hold(sync_hold));
`default_nettype wire

// >>> verification/cosd_host_pin.sv
// host side of the sync pin: follows a wanted level
// assumes: pclk is the distribution clock
`timescale 1ns/1ps
`default_nettype none
module cosd_host_pin (
    input wire logic pclk,
    input wire logic want,
    output logic sync_pin
);
    logic [1:0] age;
    initial begin
        sync_pin = 1'b0;
        age = 2'h0;
    end
    // a level shorter than two edges would be lost in the filter
    always @(posedge pclk) begin
        if (age != 2'h3) begin
            age <= age + 2'h1;
        end else if (want != sync_pin) begin
            sync_pin <= want;
            age <= 2'h0;
        end
    end
endmodule // cosd_host_pin
`default_nettype wire

// >>> verification/cosd_sync_delay_tb.sv
// self-checking bench for the sync and delay block
// assumes: zero-wait apb, groups at divider 1, qualified mode only in the last test
`timescale 1ns/1ps
`default_nettype none
module cosd_sync_delay_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic pready, pslverr, sync_hold, sync_pin, err, want = 0;
    logic lock1 = 1, lock2 = 1;
    logic [5:0] ga, gb;
    int fails = 0, cmp_count = 0;
    int ddly [6], hs [6], rise [6];
    always #10 pclk = ~pclk;
    cosd_sync_delay dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_pin(sync_pin), .lock_detect_flag_loop1(lock1),
        .lock_detect_flag_loop2(lock2), .group_clk_a(ga),
        .group_clk_b(gb), .sync_hold(sync_hold));
    cosd_host_pin host (.pclk(pclk), .want(want), .sync_pin(sync_pin));
    // write edge to first rise in half cycles: release latched at +3,
    // then six cycles plus the delay, half-step half a cycle sooner
    function automatic int exp_rise(input int d, input int h);
        return 2 * (9 + d) - h;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // an edge first, so a release is never overwritten in the same step
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // half-cycle count from the write edge to each group's first rise after half cycle 16
    task automatic measure();
        logic [5:0] prev;
        rise = '{default: 0};
        prev = ga;
        for (int hc = 1; hc <= 80; hc++) begin
            @(pclk);
            #1;
            for (int i = 0; i < 6; i++)
                if (hc > 16 && ga[i] && !prev[i] && rise[i] == 0) rise[i] = hc;
            prev = ga;
        end
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] v;
        int n;
        void'($urandom(15));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0);
        check(rd, 32'h00000100);
        apb(0, 8'h04, 0);
        check(rd, 32'h00002005);
        apb(0, 8'h24, 0);
        check(err, 1);
        check(rd, 0);
        for (int k = 0; k < 8; k++) begin
            apb(1, 8'h00, 32'h100 | (k[2] ? 32'h6 : 32'h0) | 32'(k[0]));
            want <= k[1];
            repeat (20) @(posedge pclk);
            check(sync_hold, k[2] ? k[0] : k[0] ^ k[1]);
            if (sync_hold === 1'b1) check(ga, 0);
        end
        want <= 1'b0;
        for (int r = 0; r < 4; r++) begin
            apb(1, 8'h00, 32'h100 | 32'(r[0]) << 7);
            for (int g = 0; g < 6; g++) begin
                ddly[g] = 5 + $urandom_range(7);
                hs[g] = $urandom_range(1);
                v = 32'(32'h2000 | (g == 5) << 11 | hs[g] << 10 | ddly[g]);
                apb(1, 8'h04 + 8'(4 * g), v);
                apb(0, 8'h04 + 8'(4 * g), 0);
                check(rd, v);
            end
            apb(1, 8'h1C, $urandom_range(255));
            measure();
            for (int g = 0; g < 5; g++)
                check(rise[g], exp_rise(ddly[g], hs[g]));
            check(32'(rise[5] > 16 && rise[5] < 21), 1);
            apb(1, 8'h04, 32'(32'h2000 | (1 - hs[0]) << 10 | ddly[0]));
            // the select swap itself may make an edge; skip past it
            repeat (2) @(posedge pclk);
            repeat (3) @(posedge ga[0]);
            check(pclk, 32'(hs[0]));
        end
        apb(1, 8'h00, 32'h110);
        lock1 <= 1'b0;
        repeat (15) @(posedge pclk);
        check(sync_hold, 1);
        lock1 <= 1'b1;
        repeat (20) @(posedge pclk);
        check(sync_hold, 0);
        apb(1, 8'h00, 32'h120);
        lock2 <= 1'b0;
        repeat (15) @(posedge pclk);
        check(sync_hold, 1);
        lock2 <= 1'b1;
        repeat (20) @(posedge pclk);
        check(sync_hold, 0);
        // qualified mode: the toggle only arms, the hold is the one-shot
        apb(1, 8'h00, 32'h140);
        apb(1, 8'h00, 32'h141);
        n = 0;
        repeat (30) begin
            @(negedge pclk);
            n += sync_hold;
        end
        check(n, 3);
        tally_and_finish();
    end
endmodule // cosd_sync_delay_tb
`default_nettype wire
